// >>> hdl/timer_pkg.sv
package timer_pkg;
    // ***************************************************
    // register map
    // ***************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] MODE_OFS = 8'h04;
    localparam logic [7:0] CNT_LO_OFS = 8'h08;
    localparam logic [7:0] CNT_HI_OFS = 8'h0C;
    localparam logic [7:0] RLD_LO_OFS = 8'h10;
    localparam logic [7:0] RLD_HI_OFS = 8'h14;
    // ***************************************************
    // control register fields
    // ***************************************************
    localparam int CTRL_OVF_BIT = 7;
    localparam int CTRL_EXF_BIT = 6;
    localparam int CTRL_RXSEL_BIT = 5;
    localparam int CTRL_TXSEL_BIT = 4;
    localparam int CTRL_EXTEN_BIT = 3;
    localparam int CTRL_RUN_BIT = 2;
    localparam int CTRL_CSEL_BIT = 1;
    // ***************************************************
    // mode register fields
    // ***************************************************
    localparam int MODE_OE_BIT = 1;
    localparam int MODE_DOWN_COUNT_ENABLE_BIT = 0;
    // ***************************************************
    // reset values and limits
    // ***************************************************
    localparam logic RESET_BIT = 1'b0;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] RLD_RESET = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    // ***************************************************
    // rates
    // ***************************************************
    localparam int MACHINE_DIV = 12;
    localparam int STATE_DIV = 2;
endpackage

// >>> hdl/pin_edge_sync.sv
`timescale 1ns/10ps
module pin_edge_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin
    input wire logic pin_in,
    // synchronised level and falling edge pulse
    output logic level,
    output logic fall
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    // reset high: an idle pin reads high, so release makes no false edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            last_ff <= 1'b1;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign fall = last_ff & ~sync_ff;
endmodule

// >>> hdl/rate_divider.sv
`timescale 1ns/10ps
module rate_divider #(
    parameter int DIV = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // one-cycle enable every DIV clocks
    output logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else if (cnt_ff == LAST) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end

    assign tick = (cnt_ff == LAST);
endmodule

// >>> hdl/baud_timer.sv
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module baud_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [timer_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic count_pin,
    input wire logic trigger_pin,
    // serial port side
    input wire logic timer1_ovf,
    output logic tx_bit_clk,
    output logic rx_bit_clk,
    // status out
    output logic timer_irq,
    output logic timer_output_enable
);
    import timer_pkg::*;

    // ***************************************************
    // state
    // ***************************************************
    logic [15:0] cnt_ff;
    logic [15:0] reload_ff;
    logic overflow_flag_ff;
    logic external_flag_ff;
    logic rx_clock_select_ff;
    logic tx_clock_select_ff;
    logic external_trigger_enable_ff;
    logic run_control_ff;
    logic counter_select_ff;
    logic down_count_enable_ff;
    logic timer_output_enable_ff;
    logic irq_ff;
    logic tx_bit_clk_ff;
    logic rx_bit_clk_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic mode_written_ff;

    // ***************************************************
    // pin conditioning and prescalers
    // ***************************************************
    logic trig_level;
    logic trig_fall;
    logic count_fall;
    logic machine_tick;
    logic state_tick;

    pin_edge_sync trig_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(trigger_pin),
        .level(trig_level),
        .fall(trig_fall)
    );

    pin_edge_sync count_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(count_pin),
        .level(),
        .fall(count_fall)
    );

    rate_divider #(.DIV(MACHINE_DIV)) machine_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(machine_tick)
    );

    rate_divider #(.DIV(STATE_DIV)) state_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(state_tick)
    );

    // ***************************************************
    // apb decode
    // ***************************************************
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        return (a == CTRL_OFS) || (a == MODE_OFS) || (a == CNT_LO_OFS) ||
               (a == CNT_HI_OFS) || (a == RLD_LO_OFS) || (a == RLD_HI_OFS);
    endfunction

    function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            CTRL_OFS: begin
                v[CTRL_OVF_BIT] = overflow_flag_ff;
                v[CTRL_EXF_BIT] = external_flag_ff;
                v[CTRL_RXSEL_BIT] = rx_clock_select_ff;
                v[CTRL_TXSEL_BIT] = tx_clock_select_ff;
                v[CTRL_EXTEN_BIT] = external_trigger_enable_ff;
                v[CTRL_RUN_BIT] = run_control_ff;
                v[CTRL_CSEL_BIT] = counter_select_ff;
            end
            MODE_OFS: begin
                v[MODE_OE_BIT] = timer_output_enable_ff;
                v[MODE_DOWN_COUNT_ENABLE_BIT] = down_count_enable_ff;
            end
            CNT_LO_OFS: v = cnt_ff[7:0];
            CNT_HI_OFS: v = cnt_ff[15:8];
            RLD_LO_OFS: v = reload_ff[7:0];
            RLD_HI_OFS: v = reload_ff[15:8];
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    logic apb_wr;
    logic wr_ctrl;
    logic wr_mode;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_rld_lo;
    logic wr_rld_hi;

    // writes land at the access edge, where pready is high
    assign apb_wr = psel & penable & pwrite & pready_ff;
    assign wr_ctrl = apb_wr & (paddr == CTRL_OFS);
    assign wr_mode = apb_wr & (paddr == MODE_OFS);
    assign wr_cnt_lo = apb_wr & (paddr == CNT_LO_OFS);
    assign wr_cnt_hi = apb_wr & (paddr == CNT_HI_OFS);
    assign wr_rld_lo = apb_wr & (paddr == RLD_LO_OFS);
    assign wr_rld_hi = apb_wr & (paddr == RLD_HI_OFS);

    // answer one cycle after setup: zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= RD_ZERO;
        end else begin
            pready_ff <= psel & ~penable;
            pslverr_ff <= psel & ~penable & ~is_mapped(paddr);
            if (psel & ~penable & ~pwrite) begin
                prdata_ff <= {24'h00_0000, read_byte(paddr)};
            end else begin
                prdata_ff <= RD_ZERO;
            end
        end
    end

    // ***************************************************
    // counting
    // ***************************************************
    logic baud_mode;
    logic updown;
    logic count_en;
    logic count_down;
    logic up_wrap;
    logic down_wrap;
    logic wrap;
    logic trig_evt;
    logic trig_reload;
    logic baud_ovf;

    assign baud_mode = rx_clock_select_ff | tx_clock_select_ff;
    assign updown = down_count_enable_ff & ~baud_mode;
    // state time in baud mode, machine cycle otherwise, or pin falls
    assign count_en = run_control_ff &
        (counter_select_ff ? count_fall : (baud_mode ? state_tick : machine_tick));
    assign count_down = updown & ~trig_level;
    assign up_wrap = count_en & ~count_down & (cnt_ff == CNT_MAX);
    assign down_wrap = count_en & count_down & (cnt_ff == reload_ff);
    assign wrap = up_wrap | down_wrap;
    // the trigger level steers direction in up/down mode, so no event there
    assign trig_evt = external_trigger_enable_ff & trig_fall & ~updown;
    assign trig_reload = trig_evt & ~baud_mode;
    assign baud_ovf = baud_mode & up_wrap;

    logic [15:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (trig_reload) begin
            nxt_cnt = reload_ff;
        end else if (down_wrap) begin
            nxt_cnt = CNT_MAX;
        end else if (up_wrap) begin
            nxt_cnt = reload_ff;
        end else if (count_en) begin
            nxt_cnt = count_down ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
        end
        // a software write wins; it is expected only with the timer stopped
        if (wr_cnt_lo) begin
            nxt_cnt[7:0] = pwdata[7:0];
        end
        if (wr_cnt_hi) begin
            nxt_cnt[15:8] = pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= CNT_RESET;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // a reload write may collide with a reload in baud mode; old value is used
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reload_ff <= RLD_RESET;
        end else begin
            if (wr_rld_lo) begin
                reload_ff[7:0] <= pwdata[7:0];
            end
            if (wr_rld_hi) begin
                reload_ff[15:8] <= pwdata[7:0];
            end
        end
    end

    // ***************************************************
    // control register and flags
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_clock_select_ff <= RESET_BIT;
            tx_clock_select_ff <= RESET_BIT;
            external_trigger_enable_ff <= RESET_BIT;
            run_control_ff <= RESET_BIT;
            counter_select_ff <= RESET_BIT;
        end else if (wr_ctrl) begin
            rx_clock_select_ff <= pwdata[CTRL_RXSEL_BIT];
            tx_clock_select_ff <= pwdata[CTRL_TXSEL_BIT];
            external_trigger_enable_ff <= pwdata[CTRL_EXTEN_BIT];
            run_control_ff <= pwdata[CTRL_RUN_BIT];
            counter_select_ff <= pwdata[CTRL_CSEL_BIT];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flag_ff <= RESET_BIT;
        end else if (wrap & ~baud_mode) begin
            overflow_flag_ff <= 1'b1;
        end else if (wr_ctrl) begin
            overflow_flag_ff <= pwdata[CTRL_OVF_BIT];
        end
    end

    logic exf_base;

    assign exf_base = wr_ctrl ? pwdata[CTRL_EXF_BIT] : external_flag_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_flag_ff <= RESET_BIT;
        end else if (trig_evt) begin
            external_flag_ff <= 1'b1;
        end else if (updown & wrap) begin
            external_flag_ff <= ~external_flag_ff;
        end else begin
            external_flag_ff <= exf_base;
        end
    end

    // ***************************************************
    // mode register
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            down_count_enable_ff <= RESET_BIT;
            timer_output_enable_ff <= RESET_BIT;
            mode_written_ff <= 1'b0;
        end else if (wr_mode) begin
            down_count_enable_ff <= pwdata[MODE_DOWN_COUNT_ENABLE_BIT];
            timer_output_enable_ff <= pwdata[MODE_OE_BIT];
            mode_written_ff <= 1'b1;
        end
    end

    // ***************************************************
    // interrupt request and bit clocks
    // ***************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= overflow_flag_ff | (external_flag_ff & ~down_count_enable_ff);
        end
    end

    // the serial port divides each pulse train by 16 itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_bit_clk_ff <= 1'b0;
            rx_bit_clk_ff <= 1'b0;
        end else begin
            tx_bit_clk_ff <= tx_clock_select_ff ? baud_ovf : timer1_ovf;
            rx_bit_clk_ff <= rx_clock_select_ff ? baud_ovf : timer1_ovf;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign timer_irq = irq_ff;
    assign tx_bit_clk = tx_bit_clk_ff;
    assign rx_bit_clk = rx_bit_clk_ff;
    assign timer_output_enable = timer_output_enable_ff;

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic cnt_sw_wr;

    assign cnt_sw_wr = wr_cnt_lo | wr_cnt_hi;

    down_count_enable_reset_a: assert property (!mode_written_ff |-> !down_count_enable_ff)
        else $error("down count enabled without a mode write");

    up_reload_a: assert property (up_wrap && !trig_reload && !cnt_sw_wr && !baud_mode
        |=> cnt_ff == $past(reload_ff) && overflow_flag_ff)
        else $error("up wrap did not reload or flag");

    trig_reload_a: assert property (trig_reload && !cnt_sw_wr
        |=> cnt_ff == $past(reload_ff) && external_flag_ff)
        else $error("trigger edge did not reload");

    irq_follow_a: assert property (overflow_flag_ff |=> timer_irq)
        else $error("overflow flag raised no request");

    down_wrap_a: assert property (down_wrap && !trig_reload && !cnt_sw_wr
        |=> cnt_ff == CNT_MAX && overflow_flag_ff)
        else $error("underflow did not load FFFF");

    exf_toggle_a: assert property (updown && wrap && !wr_ctrl
        |=> external_flag_ff != $past(external_flag_ff))
        else $error("external flag did not toggle");

    updown_noirq_a: assert property (down_count_enable_ff && !overflow_flag_ff
        ##1 down_count_enable_ff && !overflow_flag_ff |-> !timer_irq)
        else $error("up/down external flag raised request");

    baud_noflag_a: assert property (baud_ovf && !overflow_flag_ff && !wr_ctrl
        |=> !overflow_flag_ff && (tx_bit_clk || rx_bit_clk))
        else $error("baud rollover set the overflow flag");

    baud_trig_a: assert property (baud_mode && trig_evt && !count_en && !cnt_sw_wr
        |=> $stable(cnt_ff) && external_flag_ff)
        else $error("baud trigger edge reloaded");

    stop_hold_a: assert property (!run_control_ff && !trig_reload && !cnt_sw_wr
        |=> $stable(cnt_ff))
        else $error("count moved while stopped");

    machine_gap_a: assert property (machine_tick |=> !machine_tick [*8])
        else $error("machine tick too frequent");

    up_wrap_c: cover property (up_wrap && !baud_mode);
    down_wrap_c: cover property (down_wrap);
    baud_ovf_c: cover property (baud_ovf ##1 tx_bit_clk);
    trig_reload_c: cover property (trig_reload);
endmodule

// >>> dv/serial_partner.sv
`timescale 1ns/10ps
module serial_partner (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bit clocks from the timer
    input wire logic tx_bit_clk,
    input wire logic rx_bit_clk,
    // timer 1 overflow and pins
    output logic timer1_ovf,
    output logic count_pin,
    output logic trigger_pin
);
    int tx_cnt = 0;
    int rx_cnt = 0;
    int t1_div = 0;
    // ***************************************************
    // timer 1 stand-in: one pulse every 40 clocks
    // ***************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_div <= 0;
            timer1_ovf <= 1'b0;
        end else begin
            t1_div <= (t1_div == 39) ? 0 : t1_div + 1;
            timer1_ovf <= (t1_div == 39);
        end
    end
    // ***************************************************
    // serial port side: counts bit-clock pulses
    // ***************************************************
    always @(posedge pclk) begin
        tx_cnt <= tx_cnt + int'(tx_bit_clk === 1'b1);
        rx_cnt <= rx_cnt + int'(rx_bit_clk === 1'b1);
    end
    // ***************************************************
    // pins, pulled up while idle
    // ***************************************************
    initial begin
        count_pin = 1'b1;
        trigger_pin = 1'b1;
    end
    // pulses are long enough for the synchroniser to see each level
    task automatic pin_falls(input int n);
        repeat (n) begin
            @(posedge pclk);
            count_pin <= 1'b0;
            repeat (4) @(posedge pclk);
            count_pin <= 1'b1;
            repeat (4) @(posedge pclk);
        end
    endtask
    task automatic set_trig(input logic v);
        @(posedge pclk);
        trigger_pin <= v;
        repeat (6) @(posedge pclk);
    endtask
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin error_cnt++; \
    $display("[ERR] %s exp=%0h got=%0h", nm, ex, gt); end end
module tb_top;
    import timer_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic count_pin, trigger_pin, timer1_ovf, tx_bit_clk, rx_bit_clk;
    logic timer_irq, timer_output_enable, err;
    logic [7:0] rd;
    logic [15:0] c16;
    int error_cnt = 0;
    int n_tests = 0;
    int t0, r0;
    baud_timer i_baud_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .count_pin(count_pin), .trigger_pin(trigger_pin),
        .timer1_ovf(timer1_ovf), .tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk),
        .timer_irq(timer_irq), .timer_output_enable(timer_output_enable));
    serial_partner i_serial_partner (.pclk(pclk), .presetn(presetn), .tx_bit_clk(tx_bit_clk),
        .rx_bit_clk(rx_bit_clk), .timer1_ovf(timer1_ovf), .count_pin(count_pin),
        .trigger_pin(trigger_pin));
    // ***************************************************
    // apb master
    // ***************************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic wr16(input logic [7:0] lo, input logic [7:0] hi, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(hi, v[15:8]);
    endtask
    task automatic rd16();
        apb(1'b0, CNT_LO_OFS, 8'h00);
        c16[7:0] = rd;
        apb(1'b0, CNT_HI_OFS, 8'h00);
        c16[15:8] = rd;
    endtask
    // ***************************************************
    // scenarios
    // ***************************************************
    task automatic t_reset();
        apb(1'b0, CTRL_OFS, 8'h00);
        `CHK("ctrl", 8'h00, rd)
        apb(1'b0, MODE_OFS, 8'h00);
        `CHK("down_count_enable", 1'b0, rd[MODE_DOWN_COUNT_ENABLE_BIT])
        wr(MODE_OFS, 8'h02);
        apb(1'b0, MODE_OFS, 8'h00);
        `CHK("mode", 2'b10, rd[1:0])
        `CHK("oe", 1'b1, timer_output_enable)
        wr(MODE_OFS, 8'h00);
        apb(1'b0, 8'h3C, 8'h00);
        `CHK("slverr", 1'b1, err)
    endtask
    task automatic t_up_wrap();
        wr(CTRL_OFS, 8'h00);
        wr16(RLD_LO_OFS, RLD_HI_OFS, 16'h12F0);
        wr16(CNT_LO_OFS, CNT_HI_OFS, 16'hFFFD);
        wr(CTRL_OFS, 8'h04);
        repeat (60) @(posedge pclk);
        `CHK("irq", 1'b1, timer_irq)
        apb(1'b0, CTRL_OFS, 8'h00);
        `CHK("ovf", 1'b1, rd[CTRL_OVF_BIT])
        wr(CTRL_OFS, 8'h00);
        rd16();
        `CHK("reload", 1'b1, c16 >= 16'h12F0 && c16 <= 16'h12F3)
        repeat (100) @(posedge pclk);
        t0 = c16;
        rd16();
        `CHK("stopped", t0[15:0], c16)
        wr(CTRL_OFS, 8'h00);
        wr16(CNT_LO_OFS, CNT_HI_OFS, 16'h0000);
        wr(CTRL_OFS, 8'h04);
        repeat (120) @(posedge pclk);
        wr(CTRL_OFS, 8'h00);
        rd16();
        `CHK("div12", 1'b1, c16 >= 16'd9 && c16 <= 16'd11)
        `CHK("irq off", 1'b0, timer_irq)
    endtask
    task automatic t_trigger();
        wr16(RLD_LO_OFS, RLD_HI_OFS, 16'h5678);
        wr16(CNT_LO_OFS, CNT_HI_OFS, 16'h0011);
        wr(CTRL_OFS, 8'h06);
        i_serial_partner.set_trig(1'b0);
        i_serial_partner.set_trig(1'b1);
        wr(CTRL_OFS, 8'h00);
        rd16();
        `CHK("no trig", 16'h0011, c16)
        wr(CTRL_OFS, 8'h0E);
        i_serial_partner.set_trig(1'b0);
        i_serial_partner.set_trig(1'b1);
        apb(1'b0, CTRL_OFS, 8'h00);
        `CHK("exf", 2'b01, rd[7:6])
        `CHK("irq exf", 1'b1, timer_irq)
        wr(CTRL_OFS, 8'h00);
        rd16();
        `CHK("trig rld", 16'h5678, c16)
    endtask
    task automatic t_updown();
        wr(MODE_OFS, 8'h01);
        wr16(RLD_LO_OFS, RLD_HI_OFS, 16'h0100);
        wr16(CNT_LO_OFS, CNT_HI_OFS, 16'h0101);
        i_serial_partner.set_trig(1'b0);
        wr(CTRL_OFS, 8'h06);
        i_serial_partner.pin_falls(2);
        apb(1'b0, CTRL_OFS, 8'h00);
        `CHK("under", 2'b11, rd[7:6])
        wr(CTRL_OFS, 8'h46);
        repeat (3) @(posedge pclk);
        `CHK("exf no irq", 1'b0, timer_irq)
        wr(CTRL_OFS, 8'h40);
        rd16();
        `CHK("under ld", CNT_MAX, c16)
        i_serial_partner.set_trig(1'b1);
        wr(CTRL_OFS, 8'h46);
        i_serial_partner.pin_falls(1);
        apb(1'b0, CTRL_OFS, 8'h00);
        `CHK("over", 2'b10, rd[7:6])
        wr(CTRL_OFS, 8'h00);
        rd16();
        `CHK("over ld", 16'h0100, c16)
        wr(MODE_OFS, 8'h00);
    endtask
    task automatic t_baud();
        wr16(RLD_LO_OFS, RLD_HI_OFS, 16'hFFF0);
        wr16(CNT_LO_OFS, CNT_HI_OFS, 16'hFFF0);
        wr(CTRL_OFS, 8'h14);
        t0 = i_serial_partner.tx_cnt;
        r0 = i_serial_partner.rx_cnt;
        repeat (640) @(posedge pclk);
        t0 = i_serial_partner.tx_cnt - t0;
        r0 = i_serial_partner.rx_cnt - r0;
        `CHK("tx rate", 1'b1, t0 >= 19 && t0 <= 21)
        `CHK("rx t1", 1'b1, r0 >= 15 && r0 <= 17)
        `CHK("no irq", 1'b0, timer_irq)
        apb(1'b0, CTRL_OFS, 8'h00);
        `CHK("no ovf", 1'b0, rd[CTRL_OVF_BIT])
        // leave baud mode before touching the count
        wr(CTRL_OFS, 8'h00);
        rd16();
        `CHK("rollover", 8'hFF, c16[15:8])
        wr16(CNT_LO_OFS, CNT_HI_OFS, 16'hFFF0);
        wr(CTRL_OFS, 8'h1E);
        t0 = i_serial_partner.tx_cnt;
        i_serial_partner.pin_falls(15);
        `CHK("pin 15", 0, i_serial_partner.tx_cnt - t0)
        i_serial_partner.pin_falls(2);
        `CHK("pin 16", 1, i_serial_partner.tx_cnt - t0)
        i_serial_partner.set_trig(1'b0);
        i_serial_partner.set_trig(1'b1);
        apb(1'b0, CTRL_OFS, 8'h00);
        `CHK("baud exf", 1'b1, rd[CTRL_EXF_BIT])
        wr(CTRL_OFS, 8'h00);
        rd16();
        `CHK("no reload", 16'hFFF1, c16)
    endtask
    // ***************************************************
    // run control
    // ***************************************************
    task automatic give_verdict();
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // about 1400 clocks of traffic; twenty times that is a hang
    initial begin
        #300000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_up_wrap();
        t_trigger();
        t_updown();
        t_baud();
        give_verdict();
    end
endmodule
